// *** design/tmwc_top.v ***
// Waveform mode decoder, output compare channels and control registers of an 8-bit timer.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "tmwc_map.vh"

// ****************************************************************
// One output compare channel
// ****************************************************************
module tmwc_chan #(
	parameter IS_A = 1
) (
	// Clock and reset
	input  wire       mclk_i,
	input  wire       resetn_i,
	// Timer state
	input  wire       tick_i,
	input  wire [2:0] mode_i,
	input  wire [1:0] com_i,
	input  wire [7:0] counter_i,
	input  wire [7:0] compare_i,
	input  wire [7:0] top_i,
	input  wire       count_up_i,
	// Port side
	input  wire       port_data_i,
	input  wire       pin_dir_i,
	// Results
	output wire       pin_o,
	output wire       pin_oe_o,
	output wire       match_o,
	output wire       wave_o
);

	reg        wave_q;
	reg        wave_d;
	wire       fast_pwm;
	wire       phase_pwm;
	wire       non_pwm;
	wire       raw_match;
	wire       at_top;
	wire       special;
	wire       toggle_ok;

	// Mode class of the shared waveform mode.
	assign fast_pwm  = (mode_i == `TMWC_MODE_FAST_FIXED) || (mode_i == `TMWC_MODE_FAST_CMP_A);
	assign phase_pwm = (mode_i == `TMWC_MODE_PC_FIXED) || (mode_i == `TMWC_MODE_PC_CMP_A);
	assign non_pwm   = (mode_i == `TMWC_MODE_NORMAL) || (mode_i == `TMWC_MODE_CLEAR_MATCH);

	// A match only counts on a timer tick, so a stopped timer holds its output.
	assign raw_match = tick_i && (counter_i == compare_i);
	assign at_top    = tick_i && (counter_i == top_i);

	// A compare value at TOP with the upper field bit set drops the match itself.
	assign special   = (fast_pwm || phase_pwm) && (compare_i == top_i) && com_i[1];

	// Channel B never toggles in the PWM modes; channel A only with the high mode bit.
	assign toggle_ok = non_pwm || ((IS_A != 0) && mode_i[2]);

	// Next output level from the field, the mode class and the count position.
	always @*
	begin
		wave_d = wave_q;
		case (com_i)
			`TMWC_COM_TOGGLE:
			begin
				if (toggle_ok && raw_match)
					wave_d = ~wave_q;
			end
			`TMWC_COM_CLEAR, `TMWC_COM_SET:
			begin
				if (non_pwm)
				begin
					if (raw_match)
						wave_d = com_i[0];
				end
				else if (fast_pwm)
				begin
					// The BOTTOM action lands on the tick that wraps TOP to BOTTOM.
					if (at_top)
						wave_d = ~com_i[0];
					else if (raw_match && !special)
						wave_d = com_i[0];
				end
				else if (phase_pwm)
				begin
					// At TOP the level equals a down-counting match, which keeps
					// the pulse symmetric around BOTTOM.
					if (special)
					begin
						if (at_top)
							wave_d = ~com_i[0];
					end
					else if (raw_match)
						wave_d = count_up_i ? com_i[0] : ~com_i[0];
				end
			end
			default:
			begin
				wave_d = wave_q;
			end
		endcase
	end

	// Output compare level register.
	always @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			wave_q <= 1'b0;
		else
			wave_q <= wave_d;
	end

	// Any nonzero field hands the pin to the waveform; the driver follows direction.
	assign pin_o    = (com_i != `TMWC_COM_OFF) ? wave_q : port_data_i;
	assign pin_oe_o = pin_dir_i;
	assign match_o  = raw_match;
	assign wave_o   = wave_q;

endmodule

// ****************************************************************
// Top: registers, mode decode, events and interrupt
// ****************************************************************
module tmwc_top (
	// Clock and reset
	input  wire       mclk_i,
	input  wire       resetn_i,
	// Register port
	input  wire [7:0] reg_addr_i,
	input  wire [7:0] reg_wdata_i,
	input  wire       reg_wr_i,
	input  wire       reg_rd_i,
	output wire [7:0] reg_rdata_o,
	// Counter and compare values from the timer core
	input  wire       tick_i,
	input  wire [7:0] counter_value_i,
	input  wire       count_up_i,
	input  wire [7:0] compare_value_a_i,
	input  wire [7:0] compare_value_b_i,
	// Port pins of the two waveform outputs
	input  wire       port_data_a_i,
	input  wire       pin_dir_a_i,
	input  wire       port_data_b_i,
	input  wire       pin_dir_b_i,
	output wire       wave_out_a_o,
	output wire       wave_out_a_oe_o,
	output wire       wave_out_b_o,
	output wire       wave_out_b_oe_o,
	// Decoded mode for the timer core
	output wire [7:0] top_value_o,
	output wire       compare_a_top_source_o,
	output wire       dual_slope_o,
	output wire       mode_reserved_o,
	output wire       compare_update_o,
	output wire       overflow_flag_o,
	// Interrupt
	output wire       irq_o
);

	reg  [7:0] ctrl_a_q;
	reg        wave_high_q;
	reg  [2:0] status_q;
	reg  [2:0] status_d;
	reg  [2:0] mask_q;
	reg  [7:0] rdata_q;
	reg  [7:0] rdata_d;
	reg  [7:0] top_q;
	reg        top_src_q;
	reg        dual_q;
	reg        rsvd_q;
	reg        upd_q;
	reg        ovf_q;
	reg        ovf_evt;
	reg        upd_evt;
	wire [2:0] mode;
	wire [1:0] com_a;
	wire [1:0] com_b;
	wire [7:0] top_now;
	wire       top_from_a;
	wire       at_top;
	wire       at_bottom;
	wire       at_max;
	wire       match_a;
	wire       match_b;
	wire [2:0] events;
	wire [2:0] clear_bits;

	// Register fields; the high mode bit lives in the second control register.
	assign com_a = ctrl_a_q[`TMWC_CMP_A_MODE_HI:`TMWC_CMP_A_MODE_LO];
	assign com_b = ctrl_a_q[`TMWC_CMP_B_MODE_HI:`TMWC_CMP_B_MODE_LO];
	assign mode  = {wave_high_q, ctrl_a_q[`TMWC_WAVE_LOW_HI:`TMWC_WAVE_LOW_LO]};

	// ****************************************************************
	// Register writes
	// ****************************************************************

	// Reserved bits 3 and 2 are never stored, so they cannot read back as one.
	always @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ctrl_a_q    <= `TMWC_CTRL_A_RESET;
			wave_high_q <= `TMWC_CTRL_B_RESET;
			mask_q      <= `TMWC_EVT_RESET;
		end
		else if (reg_wr_i)
		begin
			case (reg_addr_i)
				`TMWC_OFS_CTRL_A:
				begin
					ctrl_a_q <= {reg_wdata_i[7:4], 2'b00, reg_wdata_i[1:0]};
				end
				`TMWC_OFS_CTRL_B:
				begin
					wave_high_q <= reg_wdata_i[`TMWC_WAVE_HIGH_BIT];
				end
				`TMWC_OFS_IRQ_MASK:
				begin
					mask_q <= reg_wdata_i[2:0];
				end
				default:
				begin
					mask_q <= mask_q;
				end
			endcase
		end
	end

	// ****************************************************************
	// Mode decode
	// ****************************************************************

	// TOP comes from compare A in clear-on-match and the two PWM-on-A modes.
	assign top_from_a = (mode == `TMWC_MODE_CLEAR_MATCH) || (mode == `TMWC_MODE_PC_CMP_A) ||
		(mode == `TMWC_MODE_FAST_CMP_A);
	assign top_now    = top_from_a ? compare_value_a_i : `TMWC_MAX;

	// Count positions seen on a timer tick.
	assign at_top    = tick_i && (counter_value_i == top_now);
	assign at_bottom = tick_i && (counter_value_i == `TMWC_BOTTOM);
	assign at_max    = tick_i && (counter_value_i == `TMWC_MAX);

	// Overflow point and compare buffer update point per mode. Reserved modes
	// raise neither, which keeps the core quiet if software picks them anyway.
	always @*
	begin
		ovf_evt = 1'b0;
		upd_evt = 1'b0;
		case (mode)
			`TMWC_MODE_NORMAL, `TMWC_MODE_CLEAR_MATCH:
			begin
				ovf_evt = at_max;
				upd_evt = 1'b1;
			end
			`TMWC_MODE_PC_FIXED, `TMWC_MODE_PC_CMP_A:
			begin
				ovf_evt = at_bottom;
				upd_evt = at_top;
			end
			`TMWC_MODE_FAST_FIXED:
			begin
				ovf_evt = at_max;
				upd_evt = at_top;
			end
			`TMWC_MODE_FAST_CMP_A:
			begin
				ovf_evt = at_top;
				upd_evt = at_bottom;
			end
			default:
			begin
				ovf_evt = 1'b0;
				upd_evt = 1'b0;
			end
		endcase
	end

	// Decoded outputs are registered, so they lag a mode write by one cycle.
	always @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			top_q     <= `TMWC_MAX;
			top_src_q <= 1'b0;
			dual_q    <= 1'b0;
			rsvd_q    <= 1'b0;
			upd_q     <= 1'b0;
			ovf_q     <= 1'b0;
		end
		else
		begin
			top_q     <= top_now;
			top_src_q <= top_from_a;
			dual_q    <= (mode == `TMWC_MODE_PC_FIXED) || (mode == `TMWC_MODE_PC_CMP_A);
			rsvd_q    <= (mode == `TMWC_MODE_RSVD_4) || (mode == `TMWC_MODE_RSVD_6);
			upd_q     <= upd_evt;
			ovf_q     <= ovf_evt;
		end
	end

	// ****************************************************************
	// Output compare channels
	// ****************************************************************

	tmwc_chan #(
		.IS_A        (1)
	) u_chan_a (
		.mclk_i      (mclk_i),
		.resetn_i    (resetn_i),
		.tick_i      (tick_i),
		.mode_i      (mode),
		.com_i       (com_a),
		.counter_i   (counter_value_i),
		.compare_i   (compare_value_a_i),
		.top_i       (top_now),
		.count_up_i  (count_up_i),
		.port_data_i (port_data_a_i),
		.pin_dir_i   (pin_dir_a_i),
		.pin_o       (wave_out_a_o),
		.pin_oe_o    (wave_out_a_oe_o),
		.match_o     (match_a),
		.wave_o      ()
	);

	tmwc_chan #(
		.IS_A        (0)
	) u_chan_b (
		.mclk_i      (mclk_i),
		.resetn_i    (resetn_i),
		.tick_i      (tick_i),
		.mode_i      (mode),
		.com_i       (com_b),
		.counter_i   (counter_value_i),
		.compare_i   (compare_value_b_i),
		.top_i       (top_now),
		.count_up_i  (count_up_i),
		.port_data_i (port_data_b_i),
		.pin_dir_i   (pin_dir_b_i),
		.pin_o       (wave_out_b_o),
		.pin_oe_o    (wave_out_b_oe_o),
		.match_o     (match_b),
		.wave_o      ()
	);

	// ****************************************************************
	// Sticky events and interrupt
	// ****************************************************************

	assign events = {match_b, match_a, ovf_evt};

	// Write one to clear; an event in the clearing cycle survives the clear.
	assign clear_bits = (reg_wr_i && (reg_addr_i == `TMWC_OFS_IRQ_STATUS)) ?
		reg_wdata_i[2:0] : 3'h0;

	always @*
	begin
		status_d = (status_q & ~clear_bits) | events;
	end

	always @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			status_q <= `TMWC_EVT_RESET;
		else
			status_q <= status_d;
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************

	// Read data stand for exactly one cycle; unmapped addresses read zero.
	always @*
	begin
		rdata_d = 8'h00;
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				`TMWC_OFS_CTRL_A:     rdata_d = ctrl_a_q & 8'hF3;
				`TMWC_OFS_CTRL_B:     rdata_d = {4'h0, wave_high_q, 3'h0};
				`TMWC_OFS_IRQ_STATUS: rdata_d = {5'h00, status_q};
				`TMWC_OFS_IRQ_MASK:   rdata_d = {5'h00, mask_q};
				default:              rdata_d = 8'h00;
			endcase
		end
	end

	always @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rdata_q <= 8'h00;
		else
			rdata_q <= rdata_d;
	end

	// Output assignments.
	assign reg_rdata_o            = rdata_q;
	assign top_value_o            = top_q;
	assign compare_a_top_source_o = top_src_q;
	assign dual_slope_o           = dual_q;
	assign mode_reserved_o        = rsvd_q;
	assign compare_update_o       = upd_q;
	assign overflow_flag_o        = ovf_q;
	assign irq_o                  = |(status_q & mask_q);

endmodule

`default_nettype wire

// *** design/tmwc_map.vh ***
// Register map, field positions and decode constants of the timer waveform mode control block.
// What this block does
// - Nonzero output mode field routes wave to pin.
// - Pin driver enabled only by direction bit.
// - Non-PWM channel A: off, toggle, clear, set.
// - Fast PWM A: toggle needs high bit; BOTTOM action.
// - Fast PWM compare equals TOP: skip match.
// - Phase correct A: up/down match set or clear.
// - Phase correct compare equals TOP: act at TOP.
// - Non-PWM channel B: off, toggle, clear, set.
// - Fast PWM B: value 1 reserved, 2/3 PWM.
// - Phase correct B: value 1 reserved, 2/3 PWM.
// - Control bits 3 and 2 read zero.
// - Mode joins low bits with high bit.
// - Mode selects sequence, TOP source, waveform type.
// - Mode selects compare update and overflow point.
`ifndef TMWC_MAP_VH
`define TMWC_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define TMWC_OFS_CTRL_A        8'h24
`define TMWC_OFS_CTRL_B        8'h25
`define TMWC_OFS_IRQ_STATUS    8'h35
`define TMWC_OFS_IRQ_MASK      8'h6E

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define TMWC_CMP_A_MODE_HI     7
`define TMWC_CMP_A_MODE_LO     6
`define TMWC_CMP_B_MODE_HI     5
`define TMWC_CMP_B_MODE_LO     4
`define TMWC_WAVE_LOW_HI       1
`define TMWC_WAVE_LOW_LO       0
`define TMWC_WAVE_HIGH_BIT     3
`define TMWC_EVT_OVF           0
`define TMWC_EVT_MATCH_A       1
`define TMWC_EVT_MATCH_B       2
`define TMWC_CTRL_A_RESET      8'h00
`define TMWC_CTRL_B_RESET      1'b0
`define TMWC_EVT_RESET         3'h0

// ****************************************************************
// Counter end points and waveform modes
// ****************************************************************
`define TMWC_MAX               8'hFF
`define TMWC_BOTTOM            8'h00
`define TMWC_MODE_NORMAL       3'h0
`define TMWC_MODE_PC_FIXED     3'h1
`define TMWC_MODE_CLEAR_MATCH  3'h2
`define TMWC_MODE_FAST_FIXED   3'h3
`define TMWC_MODE_RSVD_4       3'h4
`define TMWC_MODE_PC_CMP_A     3'h5
`define TMWC_MODE_RSVD_6       3'h6
`define TMWC_MODE_FAST_CMP_A   3'h7

// ****************************************************************
// Output mode field values
// ****************************************************************
`define TMWC_COM_OFF           2'h0
`define TMWC_COM_TOGGLE        2'h1
`define TMWC_COM_CLEAR         2'h2
`define TMWC_COM_SET           2'h3

`endif

// *** testbench/tmwc_properties.sv ***
// Concurrent checks on the ports of the timer waveform mode control block.
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Port checker
// ****************************************************************
module tmwc_properties (
	// Clock and reset
	input wire logic       mclk_i,
	input wire logic       resetn_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// Timer state
	input wire logic       tick_i,
	input wire logic [7:0] counter_value_i,
	input wire logic [7:0] compare_value_a_i,
	// Pins
	input wire logic       pin_dir_a_i,
	input wire logic       pin_dir_b_i,
	input wire logic       wave_out_a_oe_o,
	input wire logic       wave_out_b_oe_o,
	// Decoded mode
	input wire logic [7:0] top_value_o,
	input wire logic       compare_a_top_source_o,
	input wire logic       dual_slope_o,
	input wire logic       mode_reserved_o,
	input wire logic       compare_update_o,
	input wire logic       overflow_flag_o
);
	// One clock domain, so every check shares one clock and one reset.
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);

	// Decoded outputs lag the mode by one cycle, so each relation pairs flops of one edge.
	chk_pin_driver_en: assert property (
		wave_out_a_oe_o == pin_dir_a_i && wave_out_b_oe_o == pin_dir_b_i)
		else $error("pin driver enable differs from direction bit");
	chk_ctrl_rsvd_zero: assert property (
		reg_rd_i && reg_addr_i == 8'h24 |=> reg_rdata_o[3:2] == 2'b00)
		else $error("reserved control bits read nonzero");
	chk_top_from_a: assert property (
		compare_a_top_source_o |-> top_value_o == $past(compare_value_a_i))
		else $error("top value does not follow compare a");
	chk_top_fixed: assert property (
		!compare_a_top_source_o |-> top_value_o == 8'hFF)
		else $error("fixed top value is not full scale");
	chk_rsvd_decode: assert property (
		mode_reserved_o |-> !dual_slope_o && !compare_a_top_source_o && !compare_update_o)
		else $error("reserved mode decodes to a real mode");
	chk_ovf_on_tick: assert property (
		overflow_flag_o |-> $past(tick_i))
		else $error("overflow without a timer tick");
	chk_ovf_dual_bottom: assert property (
		overflow_flag_o && dual_slope_o |-> $past(counter_value_i) == 8'h00)
		else $error("dual slope overflow away from bottom");
	chk_ovf_fixed_max: assert property (
		overflow_flag_o && !dual_slope_o && !compare_a_top_source_o
		|-> $past(counter_value_i) == 8'hFF)
		else $error("single slope overflow away from full scale");
	chk_rsvd_no_event: assert property (
		mode_reserved_o |-> !overflow_flag_o)
		else $error("overflow in a reserved mode");

	// Main scenarios worth seeing at least once.
	cov_dual_ovf: cover property (overflow_flag_o && dual_slope_o);
	cov_top_from_a: cover property (compare_a_top_source_o && overflow_flag_o);
	cov_update_pulse: cover property (!compare_update_o ##1 compare_update_o ##1 !compare_update_o);
endmodule

bind tmwc_top tmwc_properties u_props (
	.mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .tick_i(tick_i), .counter_value_i(counter_value_i),
	.compare_value_a_i(compare_value_a_i), .pin_dir_a_i(pin_dir_a_i), .pin_dir_b_i(pin_dir_b_i),
	.wave_out_a_oe_o(wave_out_a_oe_o), .wave_out_b_oe_o(wave_out_b_oe_o),
	.top_value_o(top_value_o), .compare_a_top_source_o(compare_a_top_source_o),
	.dual_slope_o(dual_slope_o), .mode_reserved_o(mode_reserved_o),
	.compare_update_o(compare_update_o), .overflow_flag_o(overflow_flag_o)
);
`default_nettype wire

// *** testbench/test_timer8_waveform_mode_control.sv ***
// Self-checking bench of the timer waveform mode control block.
`timescale 1ns/1ps
`default_nettype none
`include "tmwc_map.vh"

module test_timer8_waveform_mode_control;
	// ****************************************************************
	// Stimulus, design and counters
	// ****************************************************************
	logic       mclk_i = 1'b0;
	logic       resetn_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, counter_value_i = 8'h00;
	logic [7:0] compare_value_a_i = 8'h40, compare_value_b_i = 8'h09;
	logic       reg_wr_i = 1'b0, reg_rd_i = 1'b0, tick_i = 1'b0, count_up_i = 1'b1;
	logic       port_data_a_i = 1'b0, pin_dir_a_i = 1'b1, port_data_b_i = 1'b1, pin_dir_b_i = 1'b0;
	wire  [7:0] reg_rdata_o, top_value_o;
	wire        wave_out_a_o, wave_out_a_oe_o, wave_out_b_o, wave_out_b_oe_o, irq_o;
	wire        compare_a_top_source_o, dual_slope_o, mode_reserved_o;
	wire        compare_update_o, overflow_flag_o;
	int         mismatches = 0;
	int         check_count = 0;
	logic [7:0] tv [3] = '{8'hFF, 8'h00, 8'h40};
	logic [1:0] code [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
	logic       expv [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

	tmwc_top uut (.mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .tick_i(tick_i), .counter_value_i(counter_value_i),
		.count_up_i(count_up_i), .compare_value_a_i(compare_value_a_i),
		.compare_value_b_i(compare_value_b_i), .port_data_a_i(port_data_a_i),
		.pin_dir_a_i(pin_dir_a_i), .port_data_b_i(port_data_b_i), .pin_dir_b_i(pin_dir_b_i),
		.wave_out_a_o(wave_out_a_o), .wave_out_a_oe_o(wave_out_a_oe_o),
		.wave_out_b_o(wave_out_b_o), .wave_out_b_oe_o(wave_out_b_oe_o),
		.top_value_o(top_value_o), .compare_a_top_source_o(compare_a_top_source_o),
		.dual_slope_o(dual_slope_o), .mode_reserved_o(mode_reserved_o),
		.compare_update_o(compare_update_o), .overflow_flag_o(overflow_flag_o), .irq_o(irq_o));

	// 40 MHz clock.
	initial
	begin
		forever #12.5 mclk_i = ~mclk_i;
	end

	// ****************************************************************
	// Compare, bus and tick tasks
	// ****************************************************************
	task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_pin(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
		end
	endtask

	// Write strobe of one cycle; the next call waits an edge, so strobes never merge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd_cmp(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1 cmp_reg(reg_rdata_o, exp);
	endtask

	// One timer tick; pin and flag results are settled when this returns.
	task automatic tick(input logic [7:0] c, input logic up);
		@(posedge mclk_i);
		tick_i <= 1'b1;
		counter_value_i <= c;
		count_up_i <= up;
		@(posedge mclk_i);
		tick_i <= 1'b0;
		#1;
	endtask

	function automatic logic ovf_exp(input int m, input logic [7:0] c);
		return (c == 8'hFF && (m == 0 || m == 2 || m == 3)) || (c == 8'h00 && (m == 1 || m == 5))
			|| (c == 8'h40 && m == 7);
	endfunction

	function automatic logic upd_exp(input int m, input logic [7:0] c);
		return m == 0 || m == 2 || (c == 8'hFF && (m == 1 || m == 3)) || (c == 8'h40 && m == 5)
			|| (c == 8'h00 && m == 7);
	endfunction

	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// A hang ends the run as a failure.
	initial
	begin
		repeat (20000) @(posedge mclk_i);
		mismatches++;
		$display("wrong value at %0t: run limit reached", $time);
		wrap_up();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		repeat (8) @(posedge mclk_i);
		resetn_i <= 1'b1;
		rd_cmp(`TMWC_OFS_CTRL_A, 8'h00);
		wr(`TMWC_OFS_CTRL_A, 8'hFF);
		rd_cmp(`TMWC_OFS_CTRL_A, 8'hF3);
		wr(`TMWC_OFS_CTRL_B, 8'hFF);
		rd_cmp(`TMWC_OFS_CTRL_B, 8'h08);
		rd_cmp(8'h30, 8'h00);
		// Every mode: decode, overflow point and compare update point.
		for (int m = 0; m < 8; m++)
		begin
			wr(`TMWC_OFS_CTRL_A, {6'h00, m[1:0]});
			wr(`TMWC_OFS_CTRL_B, {4'h0, m[2], 3'h0});
			repeat (2) @(posedge mclk_i);
			#1 cmp_pin(dual_slope_o, m == 1 || m == 5);
			cmp_pin(compare_a_top_source_o, m == 2 || m == 5 || m == 7);
			cmp_pin(mode_reserved_o, m == 4 || m == 6);
			cmp_reg(top_value_o, (m == 2 || m == 5 || m == 7) ? 8'h40 : 8'hFF);
			for (int k = 0; k < 3; k++)
			begin
				tick(tv[k], 1'b1);
				cmp_pin(overflow_flag_o, ovf_exp(m, tv[k]));
				cmp_pin(compare_update_o, upd_exp(m, tv[k]));
			end
		end
		wr(`TMWC_OFS_CTRL_B, 8'h00);
		wr(`TMWC_OFS_CTRL_A, 8'h00);
		wr(`TMWC_OFS_IRQ_STATUS, 8'h07);
		rd_cmp(`TMWC_OFS_IRQ_STATUS, 8'h00);
		@(posedge mclk_i);
		compare_value_a_i <= 8'h05;
		// Fields off: pins carry the port and follow the direction bits.
		#1 cmp_pin(wave_out_a_o, port_data_a_i);
		cmp_pin(wave_out_b_o, port_data_b_i);
		cmp_pin(wave_out_a_oe_o, 1'b1);
		cmp_pin(wave_out_b_oe_o, 1'b0);
		// Non-PWM actions in modes 0 and 2.
		for (int w = 0; w < 3; w += 2)
		begin
			foreach (code[i])
			begin
				wr(`TMWC_OFS_CTRL_A, {code[i], code[i], 2'b00, w[1:0]});
				tick(8'h05, 1'b1);
				cmp_pin(wave_out_a_o, expv[i]);
				tick(8'h09, 1'b1);
				cmp_pin(wave_out_b_o, expv[i]);
			end
		end
		@(posedge mclk_i);
		port_data_b_i <= 1'b1;
		#1 cmp_pin(wave_out_b_o, 1'b0);
		// Sticky status, mask and level interrupt.
		rd_cmp(`TMWC_OFS_IRQ_STATUS, 8'h06);
		cmp_pin(irq_o, 1'b0);
		wr(`TMWC_OFS_IRQ_MASK, 8'h02);
		cmp_pin(irq_o, 1'b1);
		wr(`TMWC_OFS_IRQ_STATUS, 8'h02);
		cmp_pin(irq_o, 1'b0);
		rd_cmp(`TMWC_OFS_IRQ_STATUS, 8'h04);
		wr(`TMWC_OFS_IRQ_MASK, 8'h01);
		tick(8'hFF, 1'b1);
		#26 cmp_pin(irq_o, 1'b1);
		rd_cmp(`TMWC_OFS_IRQ_MASK, 8'h01);
		// Fast PWM: match action, bottom action, compare at top.
		// Channel B never gets the reserved value 1 in a PWM mode.
		wr(`TMWC_OFS_CTRL_A, 8'hB3);
		tick(8'h05, 1'b1);
		cmp_pin(wave_out_a_o, 1'b0);
		tick(8'h09, 1'b1);
		cmp_pin(wave_out_b_o, 1'b1);
		tick(8'hFF, 1'b1);
		cmp_pin(wave_out_a_o, 1'b1);
		cmp_pin(wave_out_b_o, 1'b0);
		@(posedge mclk_i);
		compare_value_b_i <= 8'hFF;
		wr(`TMWC_OFS_CTRL_A, 8'h63);
		tick(8'hFF, 1'b1);
		cmp_pin(wave_out_b_o, 1'b1);
		tick(8'h05, 1'b1);
		cmp_pin(wave_out_a_o, 1'b1);
		wr(`TMWC_OFS_CTRL_B, 8'h08);
		tick(8'h05, 1'b1);
		cmp_pin(wave_out_a_o, 1'b0);
		// Phase correct: up and down matches, compare at top.
		@(posedge mclk_i);
		compare_value_b_i <= 8'h09;
		wr(`TMWC_OFS_CTRL_B, 8'h00);
		wr(`TMWC_OFS_CTRL_A, 8'hB1);
		tick(8'h05, 1'b1);
		cmp_pin(wave_out_a_o, 1'b0);
		tick(8'h05, 1'b0);
		cmp_pin(wave_out_a_o, 1'b1);
		tick(8'h09, 1'b1);
		cmp_pin(wave_out_b_o, 1'b1);
		tick(8'h09, 1'b0);
		cmp_pin(wave_out_b_o, 1'b0);
		@(posedge mclk_i);
		compare_value_b_i <= 8'hFF;
		wr(`TMWC_OFS_CTRL_A, 8'h61);
		tick(8'hFF, 1'b1);
		cmp_pin(wave_out_b_o, 1'b1);
		tick(8'h05, 1'b1);
		cmp_pin(wave_out_a_o, 1'b1);
		wr(`TMWC_OFS_CTRL_B, 8'h08);
		tick(8'h05, 1'b1);
		cmp_pin(wave_out_a_o, 1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
